// ---- core/cascade_single_wire_transceiver.sv ----
// cascade single-wire transceiver with its transmit word buffer
// assumes all inputs synchronous to CLK_I and control settings held steady
`timescale 1ns/10ps
`include "cascade_consts.svh"

module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem[rd_q];

    // storage needs no reset, only the pointers, count and ready do
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_q] <= in_data_i;
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
        end
    end

    // ready is registered so the top port comes from a flop
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count_q    <= '0;
            in_ready_o <= 1'b0;
        end
        else
        begin
            count_q    <= count_q + (AW+1)'(push) - (AW+1)'(pop);
            in_ready_o <= (count_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
        end
    end
endmodule

module cascade_single_wire_transceiver (
    input  wire logic                  CLK_I,
    input  wire logic                  RST_B_I,
    input  wire logic                  CHAIN_INPUT_LINE_I,
    output logic                       CHAIN_OUTPUT_LINE_O,
    input  wire logic                  TRANSCEIVER_ENABLE_I,
    input  wire logic                  TX_MODE_SELECT_I,
    input  wire logic                  PASS_THROUGH_CLEAR_I,
    input  wire logic [7:0]            BIT_THRESHOLD_I,
    input  wire logic [7:0]            RESET_TIME_I,
    input  wire logic [7:0]            BIT_PERIOD_I,
    input  wire logic [7:0]            ONE_PULSE_COUNT_I,
    input  wire logic [7:0]            ZERO_PULSE_COUNT_I,
    input  wire logic                  BIT_ERROR_IRQ_ENABLE_I,
    input  wire cascade_pkg::cas_word_s TX_WORD_I,
    input  wire logic                  TX_VALID_I,
    output logic                       TX_READY_O,
    input  wire logic                  TX_SEND_RESET_I,
    output cascade_pkg::cas_word_s     RX_WORD_O,
    output cascade_pkg::rx_flags_s     RX_FLAGS_O,
    output logic                       TRANSMIT_TRIGGER_O,
    output logic                       TX_EMPTY_FLAG_O,
    output logic                       TRANSCEIVER_INTERRUPT_O,
    output logic                       BIT_ERROR_IRQ_O
);
    logic [7:0]            div_q;
    logic [3:0]            slow_q;
    logic                  cascade_clock;
    logic                  slow_tick;
    logic                  line_q;
    logic                  rise;
    logic                  fall;
    logic                  rx_mode;
    logic                  rx_act;
    logic [7:0]            reset_time_counter_q;
    logic                  bus_rst_ev;
    cascade_pkg::rx_state_e rx_state_q;
    logic [7:0]            high_cnt_q;
    logic [7:0]            bit_period_counter_q;
    logic [4:0]            rx_idx_q;
    logic [23:0]           rx_shift_q;
    logic                  rx_bit;
    logic                  pc_zero;
    logic                  rx_done;
    logic                  rx_err;
    cascade_pkg::tx_state_e tx_state_q;
    logic [11:0]           tcnt_q;
    logic [4:0]            tx_idx_q;
    logic [23:0]           tx_shift_q;
    logic                  tx_line_q;
    logic                  tx_go;
    logic                  tx_pop;
    logic                  tx_done;
    logic                  tx_end;
    logic [23:0]           fifo_data;
    logic                  fifo_valid;
    logic [7:0]            next_high;
    logic [7:0]            low_len;

    // cascade clock and the sixteen-times slower reset clock as enables
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            div_q  <= 8'h00;
            slow_q <= 4'h0;
        end
        else
        begin
            div_q <= cascade_clock ? 8'h00 : div_q + 8'h01;
            if (cascade_clock)
            begin
                slow_q <= slow_q + 4'h1;
            end
        end
    end
    assign cascade_clock = (div_q == `CAS_CLK_DIV - 8'h01);
    assign slow_tick     = cascade_clock && (slow_q == `CAS_SLOW_DIV);

    // edge detection on the line, against a copy one cycle behind the pin
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            line_q <= 1'b0;
        end
        else
        begin
            line_q <= CHAIN_INPUT_LINE_I;
        end
    end
    assign rise    = CHAIN_INPUT_LINE_I && !line_q;
    assign fall    = !CHAIN_INPUT_LINE_I && line_q;
    assign rx_mode = TRANSCEIVER_ENABLE_I && !TX_MODE_SELECT_I;
    // decoding stops after a bit error until the next bus reset
    assign rx_act  = rx_mode && RX_FLAGS_O.receive_enable
                     && !RX_FLAGS_O.bit_error_flag;

    // reset time down-counter, reloaded by every line edge
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            reset_time_counter_q <= `CAS_RESET_TIME_RST;
        end
        else if (!rx_mode || rise || fall)
        begin
            reset_time_counter_q <= RESET_TIME_I;
        end
        else if (slow_tick && reset_time_counter_q != 8'h00)
        begin
            reset_time_counter_q <= reset_time_counter_q - 8'h01;
        end
    end
    // fires once per steady stretch; counter then rests at zero
    assign bus_rst_ev = rx_mode && slow_tick && (reset_time_counter_q == 8'h01);

    // bit decision against the threshold at the falling edge
    assign rx_bit  = (high_cnt_q >= BIT_THRESHOLD_I);
    assign pc_zero = cascade_clock && (bit_period_counter_q == 8'h01);
    assign rx_done = rx_act && rx_state_q == cascade_pkg::RX_HIGH && fall
                     && rx_idx_q == `CAS_BIT_LAST;
    assign rx_err  = rx_act && pc_zero
                     && ((rx_state_q == cascade_pkg::RX_HIGH && !fall)
                      || (rx_state_q == cascade_pkg::RX_LOW && !rise));

    // receive sequencer: high count, period count, bit index
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rx_state_q <= cascade_pkg::RX_IDLE;
            high_cnt_q <= 8'h00;
            bit_period_counter_q <= 8'h00;
            rx_idx_q   <= 5'h00;
        end
        else if (!rx_act || bus_rst_ev || rx_err || rx_done)
        begin
            rx_state_q <= cascade_pkg::RX_IDLE;
            rx_idx_q   <= 5'h00;
        end
        else if (rise && rx_state_q != cascade_pkg::RX_HIGH)
        begin
            rx_state_q <= cascade_pkg::RX_HIGH;
            high_cnt_q <= 8'h00;
            bit_period_counter_q <= BIT_PERIOD_I;
        end
        else if (fall && rx_state_q == cascade_pkg::RX_HIGH)
        begin
            rx_state_q <= cascade_pkg::RX_LOW;
            rx_idx_q   <= rx_idx_q + 5'h01;
        end
        else if (cascade_clock && rx_state_q != cascade_pkg::RX_IDLE)
        begin
            bit_period_counter_q <= bit_period_counter_q - 8'h01;
            if (rx_state_q == cascade_pkg::RX_HIGH && high_cnt_q != 8'hFF)
            begin
                high_cnt_q <= high_cnt_q + 8'h01;
            end
        end
    end

    // shift register, first bit ends up in the top of byte zero
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rx_shift_q <= 24'h000000;
            RX_WORD_O  <= '0;
        end
        else if (rx_act && fall && rx_state_q == cascade_pkg::RX_HIGH)
        begin
            rx_shift_q <= {rx_shift_q[22:0], rx_bit};
            if (rx_done)
            begin
                RX_WORD_O <= {rx_shift_q[22:0], rx_bit};
            end
        end
    end

    // status flags; a hardware set wins over a rise or software clear, and a bus reset wins over frame and error updates
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            RX_FLAGS_O <= '0;
        end
        else
        begin
            if (rise)
            begin
                RX_FLAGS_O.bus_reset_flag <= 1'b0;
            end
            if (PASS_THROUGH_CLEAR_I)
            begin
                RX_FLAGS_O.pass_through_flag <= 1'b0;
            end
            if (rx_done)
            begin
                RX_FLAGS_O.frame_full_flag   <= 1'b1;
                RX_FLAGS_O.pass_through_flag <= 1'b1;
                RX_FLAGS_O.receive_enable    <= 1'b0;
            end
            if (rx_err)
            begin
                RX_FLAGS_O.bit_error_flag  <= 1'b1;
                RX_FLAGS_O.frame_full_flag <= 1'b0;
            end
            if (bus_rst_ev)
            begin
                RX_FLAGS_O.bus_reset_flag    <= 1'b1;
                RX_FLAGS_O.frame_full_flag   <= 1'b0;
                RX_FLAGS_O.bit_error_flag    <= 1'b0;
                RX_FLAGS_O.pass_through_flag <= 1'b0;
                RX_FLAGS_O.receive_enable    <= 1'b1;
            end
        end
    end

    // output mux: transmitter, bypass, or idle low while bus reset holds
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            CHAIN_OUTPUT_LINE_O <= 1'b0;
        end
        else if (TX_MODE_SELECT_I)
        begin
            CHAIN_OUTPUT_LINE_O <= tx_line_q;
        end
        else
        begin
            CHAIN_OUTPUT_LINE_O <= RX_FLAGS_O.pass_through_flag && !RX_FLAGS_O.bus_reset_flag
                                   && CHAIN_INPUT_LINE_I;
        end
    end

    // transmit word buffer; a push stands for load plus trigger
    word_fifo #(
        .WIDTH (`CAS_WORD_BITS),
        .DEPTH (`CAS_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .in_data_i   (TX_WORD_I),
        .in_valid_i  (TX_VALID_I),
        .in_ready_o  (TX_READY_O),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (tx_pop)
    );

    // switching mode mid-word aborts it, hence the disable-first sequence
    assign tx_go     = TRANSCEIVER_ENABLE_I && TX_MODE_SELECT_I;
    assign tx_pop    = tx_go && tx_state_q == cascade_pkg::TX_IDLE && fifo_valid;
    assign tx_end    = cascade_clock && tcnt_q <= 12'h001;
    assign tx_done   = tx_go && tx_end && tx_state_q == cascade_pkg::TX_LOW
                       && tx_idx_q == `CAS_BIT_LAST;
    assign next_high = tx_shift_q[22] ? ONE_PULSE_COUNT_I : ZERO_PULSE_COUNT_I;
    // low part fills the period; a too short period still gives one tick
    assign low_len   = (BIT_PERIOD_I > (tx_shift_q[23] ? ONE_PULSE_COUNT_I : ZERO_PULSE_COUNT_I))
                       ? BIT_PERIOD_I - (tx_shift_q[23] ? ONE_PULSE_COUNT_I : ZERO_PULSE_COUNT_I)
                       : 8'h01;

    // transmit sequencer: timed high, timed low, optional reset hold
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            tx_state_q <= cascade_pkg::TX_IDLE;
            tcnt_q     <= 12'h000;
            tx_idx_q   <= 5'h00;
            tx_shift_q <= 24'h000000;
            tx_line_q  <= 1'b0;
        end
        else if (!tx_go)
        begin
            tx_state_q <= cascade_pkg::TX_IDLE;
            tx_line_q  <= 1'b0;
        end
        else
        begin
            case (tx_state_q)
                cascade_pkg::TX_IDLE:
                begin
                    tx_idx_q <= 5'h00;
                    if (fifo_valid)
                    begin
                        tx_shift_q <= fifo_data;
                        tx_line_q  <= 1'b1;
                        tcnt_q     <= {4'h0, fifo_data[23] ? ONE_PULSE_COUNT_I
                                                           : ZERO_PULSE_COUNT_I};
                        tx_state_q <= cascade_pkg::TX_HIGH;
                    end
                    else if (TX_SEND_RESET_I)
                    begin
                        tx_line_q  <= 1'b0;
                        tcnt_q     <= {RESET_TIME_I, 4'h0};
                        tx_state_q <= cascade_pkg::TX_RESET;
                    end
                end
                cascade_pkg::TX_HIGH:
                begin
                    if (tx_end)
                    begin
                        tx_line_q  <= 1'b0;
                        tcnt_q     <= {4'h0, low_len};
                        tx_state_q <= cascade_pkg::TX_LOW;
                    end
                    else if (cascade_clock)
                    begin
                        tcnt_q <= tcnt_q - 12'h001;
                    end
                end
                cascade_pkg::TX_LOW:
                begin
                    if (tx_done)
                    begin
                        tx_state_q <= cascade_pkg::TX_IDLE;
                    end
                    else if (tx_end)
                    begin
                        tx_idx_q   <= tx_idx_q + 5'h01;
                        tx_shift_q <= {tx_shift_q[22:0], 1'b0};
                        tx_line_q  <= 1'b1;
                        tcnt_q     <= {4'h0, next_high};
                        tx_state_q <= cascade_pkg::TX_HIGH;
                    end
                    else if (cascade_clock)
                    begin
                        tcnt_q <= tcnt_q - 12'h001;
                    end
                end
                default:
                begin
                    if (tx_end)
                    begin
                        tx_state_q <= cascade_pkg::TX_IDLE;
                    end
                    else if (cascade_clock)
                    begin
                        tcnt_q <= tcnt_q - 12'h001;
                    end
                end
            endcase
        end
    end

    // trigger and empty flag; the empty flag drops the trigger
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            TRANSMIT_TRIGGER_O <= 1'b0;
            TX_EMPTY_FLAG_O    <= 1'b0;
        end
        else if (tx_pop)
        begin
            TRANSMIT_TRIGGER_O <= 1'b1;
            TX_EMPTY_FLAG_O    <= 1'b0;
        end
        else if (tx_done)
        begin
            TRANSMIT_TRIGGER_O <= 1'b0;
            TX_EMPTY_FLAG_O    <= 1'b1;
        end
    end

    // interrupt pulse per word and the gated bit error request
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            TRANSCEIVER_INTERRUPT_O <= 1'b0;
            BIT_ERROR_IRQ_O         <= 1'b0;
        end
        else
        begin
            TRANSCEIVER_INTERRUPT_O <= rx_done || tx_done;
            BIT_ERROR_IRQ_O <= RX_FLAGS_O.bit_error_flag && BIT_ERROR_IRQ_ENABLE_I;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_frame_flags;
        RX_FLAGS_O.frame_full_flag && RX_FLAGS_O.pass_through_flag
        && !RX_FLAGS_O.receive_enable && TRANSCEIVER_INTERRUPT_O;
    endsequence
    sequence s_reset_flags;
        RX_FLAGS_O.bus_reset_flag && RX_FLAGS_O.receive_enable && !RX_FLAGS_O.bit_error_flag
        && !RX_FLAGS_O.frame_full_flag && !RX_FLAGS_O.pass_through_flag;
    endsequence

    a_decode_one: assert property (rx_act && fall && rx_state_q == cascade_pkg::RX_HIGH
        && high_cnt_q >= BIT_THRESHOLD_I |=> rx_shift_q[0])
        else $error("long high pulse not decoded as one");
    a_decode_zero: assert property (rx_act && fall && rx_state_q == cascade_pkg::RX_HIGH
        && high_cnt_q < BIT_THRESHOLD_I |=> !rx_shift_q[0])
        else $error("short high pulse not decoded as zero");
    a_reset_flags: assert property (bus_rst_ev |=> s_reset_flags)
        else $error("bus reset flags wrong");
    a_bypass_off: assert property (RX_FLAGS_O.bus_reset_flag && !TX_MODE_SELECT_I
        |=> !CHAIN_OUTPUT_LINE_O)
        else $error("bypass active during bus reset");
    a_bypass_path: assert property (RX_FLAGS_O.pass_through_flag && !RX_FLAGS_O.bus_reset_flag
        && !TX_MODE_SELECT_I |=> CHAIN_OUTPUT_LINE_O == $past(CHAIN_INPUT_LINE_I))
        else $error("bypass does not follow input");
    a_frame_full: assert property (rx_done |=> s_frame_flags)
        else $error("frame completion flags wrong");
    a_reset_clear: assert property (rise && RX_FLAGS_O.bus_reset_flag && !bus_rst_ev
        |=> !RX_FLAGS_O.bus_reset_flag)
        else $error("bus reset flag not cleared by rising edge");
    a_bit_error: assert property (rx_err && !bus_rst_ev
        |=> RX_FLAGS_O.bit_error_flag && !RX_FLAGS_O.frame_full_flag)
        else $error("timeout did not flag bit error");
    a_error_halt: assert property (RX_FLAGS_O.bit_error_flag && !bus_rst_ev
        |=> rx_state_q == cascade_pkg::RX_IDLE)
        else $error("decoding continued after bit error");
    a_empty_trigger: assert property (tx_done |=> TX_EMPTY_FLAG_O && !TRANSMIT_TRIGGER_O)
        else $error("empty flag did not clear trigger");
    a_error_irq: assert property (RX_FLAGS_O.bit_error_flag && BIT_ERROR_IRQ_ENABLE_I
        |=> BIT_ERROR_IRQ_O)
        else $error("bit error interrupt missing");
endmodule

// ---- core/cascade_consts.svh ----
// constants of the cascade single-wire transceiver
// assumes inclusion by bare name from the package and the design file
`ifndef CASCADE_CONSTS_SVH
`define CASCADE_CONSTS_SVH

// system clocks per cascade clock tick, adjustable for baud rate
`define CAS_CLK_DIV      8'h04
// slow counter value that marks the reset-time tick, one per 16 cascade ticks
`define CAS_SLOW_DIV     4'hF
// index of the last bit of a 24-bit word
`define CAS_BIT_LAST     5'h17
// bits per word
`define CAS_WORD_BITS    24
// depth of the transmit word buffer
`define CAS_FIFO_DEPTH   8
// reset value of the reset time counter
`define CAS_RESET_TIME_RST 8'h80

`endif

// ---- core/cascade_pkg.sv ----
// types of the cascade single-wire transceiver
// assumes the constants header sits beside it
`include "cascade_consts.svh"

package cascade_pkg;

    // three data bytes, byte zero goes out and arrives first
    typedef struct packed {
        logic [7:0] data_byte_zero;
        logic [7:0] data_byte_one;
        logic [7:0] data_byte_two;
    } cas_word_s;

    // receive status flags
    typedef struct packed {
        logic bus_reset_flag;
        logic frame_full_flag;
        logic bit_error_flag;
        logic pass_through_flag;
        logic receive_enable;
    } rx_flags_s;

    typedef enum logic [1:0] {RX_IDLE, RX_HIGH, RX_LOW} rx_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_HIGH, TX_LOW, TX_RESET} tx_state_e;

endpackage

// ---- verif/chain_partner.sv ----
// upstream master and downstream listener of the single-wire chain
// assumes a 50 MHz clock; pulse widths are counted in system clocks
`timescale 1ns/10ps
module chain_partner (
    input  wire logic        clk_i,
    input  wire logic        out_line_i,
    output logic             in_line_o,
    output logic [23:0]      heard_o,
    output int               heard_n_o
);
    int hi_len;

    initial
    begin
        in_line_o = 1'b0;
        heard_o = 24'h000000;
        heard_n_o = 0;
        hi_len = 0;
    end

    // aligns to an edge first, so back-to-back calls never drive twice in a step
    task automatic hold(input logic lvl, input int n);
        @(posedge clk_i);
        in_line_o <= lvl;
        repeat (n - 1) @(posedge clk_i);
    endtask

    // msb first; ones 24 clocks high, zeros 8, each bit 40 clocks in all
    task automatic send(input logic [23:0] w, input int n);
        for (int i = 23; i > 23 - n; i--)
        begin
            hold(1'b1, w[i] ? 24 : 8);
            hold(1'b0, w[i] ? 16 : 32);
        end
    endtask

    // listener judges each high pulse by length, so tick jitter is tolerated
    always @(posedge clk_i)
    begin
        if (out_line_i === 1'b1)
            hi_len <= hi_len + 1;
        else if (hi_len != 0)
        begin
            heard_o <= {heard_o[22:0], hi_len >= 16};
            heard_n_o <= heard_n_o + 1;
            hi_len <= 0;
        end
    end
endmodule

// ---- verif/cascade_single_wire_transceiver_test.sv ----
// self-checking bench of the single-wire transceiver
// assumes the chain partner model beside it
`timescale 1ns/10ps
module cascade_single_wire_transceiver_test;
    logic CLK_I, RST_B_I, CHAIN_INPUT_LINE_I, CHAIN_OUTPUT_LINE_O, TX_READY_O;
    logic TRANSCEIVER_ENABLE_I = 0, TX_MODE_SELECT_I = 0, PASS_THROUGH_CLEAR_I = 0;
    logic BIT_ERROR_IRQ_ENABLE_I = 0, TX_VALID_I = 0, TX_SEND_RESET_I = 0;
    logic TRANSMIT_TRIGGER_O, TX_EMPTY_FLAG_O, TRANSCEIVER_INTERRUPT_O, BIT_ERROR_IRQ_O;
    logic [7:0] BIT_THRESHOLD_I = 8'h04, RESET_TIME_I = 8'h02, BIT_PERIOD_I = 8'h0C;
    logic [7:0] ONE_PULSE_COUNT_I = 8'h06, ZERO_PULSE_COUNT_I = 8'h02;
    cascade_pkg::cas_word_s TX_WORD_I = 24'h000000, RX_WORD_O;
    cascade_pkg::rx_flags_s RX_FLAGS_O;
    logic [23:0] heard;
    int heard_n, i0, irq_n = 0, err_total = 0, comparisons = 0;

    cascade_single_wire_transceiver u_cascade_single_wire_transceiver (.CLK_I, .RST_B_I,
        .CHAIN_INPUT_LINE_I, .CHAIN_OUTPUT_LINE_O, .TRANSCEIVER_ENABLE_I, .TX_MODE_SELECT_I,
        .PASS_THROUGH_CLEAR_I, .BIT_THRESHOLD_I, .RESET_TIME_I, .BIT_PERIOD_I,
        .ONE_PULSE_COUNT_I, .ZERO_PULSE_COUNT_I, .BIT_ERROR_IRQ_ENABLE_I, .TX_WORD_I,
        .TX_VALID_I, .TX_READY_O, .TX_SEND_RESET_I, .RX_WORD_O, .RX_FLAGS_O,
        .TRANSMIT_TRIGGER_O, .TX_EMPTY_FLAG_O, .TRANSCEIVER_INTERRUPT_O, .BIT_ERROR_IRQ_O);
    chain_partner u_chain_partner (.clk_i(CLK_I), .out_line_i(CHAIN_OUTPUT_LINE_O),
        .in_line_o(CHAIN_INPUT_LINE_I), .heard_o(heard), .heard_n_o(heard_n));

    // 50 MHz clock and a count of word interrupt pulses
    initial
    begin
        CLK_I = 1'b0;
        forever #10 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I)
        if (TRANSCEIVER_INTERRUPT_O === 1'b1)
            irq_n <= irq_n + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic drive(input logic en, input logic md);
        @(posedge CLK_I);
        TRANSCEIVER_ENABLE_I <= en;
        TX_MODE_SELECT_I <= md;
    endtask

    // the first word ends in a zero bit and the second in a one bit
    task automatic rx_frames();
        logic [23:0] w;
        for (int k = 0; k < 2; k++)
        begin
            w = k ? 24'h3CA5E7 : 24'hA5C31E;
            i0 = irq_n;
            u_chain_partner.hold(1'b0, 250);
            @(negedge CLK_I);
            chk(RX_FLAGS_O, 5'h11);
            chk(CHAIN_OUTPUT_LINE_O, 0);
            u_chain_partner.send(w, 24);
            u_chain_partner.hold(1'b0, 4);
            @(negedge CLK_I);
            chk(RX_WORD_O, w);
            chk(RX_FLAGS_O, 5'h0A);
            chk(irq_n - i0, 1);
            u_chain_partner.hold(1'b1, 3);
            @(negedge CLK_I);
            chk(CHAIN_OUTPUT_LINE_O, 1);
        end
        @(posedge CLK_I);
        PASS_THROUGH_CLEAR_I <= 1'b1;
        @(posedge CLK_I);
        PASS_THROUGH_CLEAR_I <= 1'b0;
        @(negedge CLK_I);
        chk(RX_FLAGS_O.pass_through_flag, 0);
        $display("rx frames done");
    endtask

    // a missing rise, ignored bits after it, then bit 23 stuck high
    task automatic bit_faults();
        u_chain_partner.hold(1'b0, 250);
        u_chain_partner.send(24'hA5C31E, 3);
        u_chain_partner.hold(1'b0, 30);
        @(negedge CLK_I);
        chk(RX_FLAGS_O.bit_error_flag, 1);
        chk(BIT_ERROR_IRQ_O, 0);
        @(posedge CLK_I);
        BIT_ERROR_IRQ_ENABLE_I <= 1'b1;
        repeat (2) @(negedge CLK_I);
        chk(BIT_ERROR_IRQ_O, 1);
        u_chain_partner.send(24'h0F0F0F, 24);
        @(negedge CLK_I);
        chk({RX_WORD_O, RX_FLAGS_O.frame_full_flag}, {24'h3CA5E7, 1'b0});
        u_chain_partner.hold(1'b0, 250);
        @(negedge CLK_I);
        chk(RX_FLAGS_O, 5'h11);
        u_chain_partner.send(24'h3CA5E7, 23);
        u_chain_partner.hold(1'b1, 60);
        @(negedge CLK_I);
        chk(RX_FLAGS_O[3:1], 3'b010);
        u_chain_partner.hold(1'b0, 4);
        $display("bit faults done");
    endtask

    task automatic push(input logic [23:0] w);
        int n = 0;
        @(posedge CLK_I);
        TX_WORD_I <= w;
        TX_VALID_I <= 1'b1;
        do @(posedge CLK_I); while (TX_READY_O !== 1'b1 && ++n < 99);
        TX_VALID_I <= 1'b0;
    endtask

    // fill the buffer while disabled, then let it drain onto the line
    task automatic tx_words();
        int n;
        int base;
        drive(1'b0, 1'b0);
        drive(1'b0, 1'b1);
        PASS_THROUGH_CLEAR_I <= 1'b1;
        for (int k = 0; k < 8; k++)
            push(24'hC35A81 + k[23:0]);
        @(negedge CLK_I);
        chk(TX_READY_O, 0);
        base = heard_n;
        i0 = irq_n;
        drive(1'b1, 1'b1);
        for (int k = 0; k < 8; k++)
        begin
            for (n = 0; heard_n < base + 24 * (k + 1) && n < 3000; n++)
                @(negedge CLK_I);
            chk(heard, 24'hC35A81 + k[23:0]);
            chk({TRANSMIT_TRIGGER_O, TX_EMPTY_FLAG_O}, 2'b10);
        end
        repeat (60) @(negedge CLK_I);
        chk({TRANSMIT_TRIGGER_O, TX_EMPTY_FLAG_O, TX_READY_O}, 3'b011);
        chk(irq_n - i0, 8);
        $display("tx words done");
    endtask

    // a reset hold on the line keeps the next word back until it ends
    task automatic tx_reset();
        int n;
        int base;
        @(posedge CLK_I);
        TX_SEND_RESET_I <= 1'b1;
        @(posedge CLK_I);
        TX_SEND_RESET_I <= 1'b0;
        push(24'h5AA55A);
        base = heard_n;
        repeat (60) @(negedge CLK_I);
        chk({TRANSMIT_TRIGGER_O, CHAIN_OUTPUT_LINE_O}, 2'b00);
        for (n = 0; heard_n < base + 24 && n < 3000; n++)
            @(negedge CLK_I);
        chk(heard, 24'h5AA55A);
        $display("tx reset done");
    endtask

    initial
    begin
        RST_B_I = 1'b0;
        repeat (10) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        drive(1'b1, 1'b0);
        rx_frames();
        bit_faults();
        tx_words();
        tx_reset();
        results();
    end

    // the whole run needs about 16000 cycles
    initial
    begin
        #1000000;
        err_total++;
        results();
    end
endmodule
